// file: logic/crx_pkg.sv
// Package for the codec receive slot framing configuration block
package crx_pkg;

   // Register indices as printed (not byte addresses): byte address = 4*idx
   localparam logic [15:0] CRX_LINK_CONTROL_IDX = 16'hFFD5;
   localparam logic [15:0] CRX_SLOT_FORMAT_IDX = 16'hFFD6;
   localparam logic [15:0] CRX_DIVIDER_IDX = 16'hFFD4;
   localparam logic [15:0] CRX_MODE_IDX = 16'hFFE0;
   localparam logic [17:0] CRX_LINK_CONTROL_ADDR = {CRX_LINK_CONTROL_IDX, 2'b00};
   localparam logic [17:0] CRX_SLOT_FORMAT_ADDR = {CRX_SLOT_FORMAT_IDX, 2'b00};
   localparam logic [17:0] CRX_DIVIDER_ADDR = {CRX_DIVIDER_IDX, 2'b00};
   localparam logic [17:0] CRX_MODE_ADDR = {CRX_MODE_IDX, 2'b00};

   // Reset values
   localparam logic [7:0] CRX_LINK_CONTROL_RST = 8'h30;
   localparam logic [7:0] CRX_SLOT_FORMAT_RST = 8'h00;
   localparam logic [2:0] CRX_DIVIDER_RST = 3'h0;
   localparam logic [2:0] CRX_MODE_RST = 3'h0;

   // Mode in which the configuration applies
   localparam logic [2:0] CRX_MODE_FIVE = 3'h5;

   // Field positions
   localparam int CRX_WIDTH_LSB = 3;
   localparam int CRX_LENGTH_LSB = 0;
   localparam int CRX_DATA_DELAY_POS = 7;
   localparam int CRX_TRISTATE_POS = 6;
   localparam int CRX_CLK_POL_POS = 5;
   localparam int CRX_SYNC_POL_POS = 4;
   localparam int CRX_SYNC_LEN_POS = 3;
   localparam int CRX_BYTE_ORDER_POS = 2;
   localparam int CRX_CLK_DIR_POS = 1;
   localparam int CRX_SYNC_DIR_POS = 0;
   localparam logic [7:0] CRX_SLOT_FORMAT_MASK = 8'h3F;

   // Slot count of one frame (slot 0 is the command slot)
   localparam logic [3:0] CRX_SLOTS_PER_FRAME = 4'h8;

   typedef struct packed {
      logic data_delay_bit;
      logic tristate_enable_bit;
      logic clock_polarity_bit;
      logic sync_polarity_bit;
      logic sync_length_bit;
      logic byte_order_bit;
      logic clock_direction_bit;
      logic sync_direction_bit;
   } crx_link_type;

   typedef struct packed {
      logic [1:0] reserved;
      logic [2:0] sample_width_code;
      logic [2:0] slot_length_code;
   } crx_format_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } crx_apb_req_type;

endpackage

// file: logic/crx_clk_div.sv
// Serial clock divider from the master clock output
`timescale 1ns/1ps
`default_nettype none
module crx_clk_div
   import crx_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Control
   input wire logic [2:0] ratio_code_in,
   input wire logic mclk_in,
   // Output
   output logic sclk_out,
   output logic sclk_rise_out,
   output logic sclk_fall_out
);
   logic mclk_q;
   logic [3:0] count_q;
   logic [3:0] limit;
   logic [3:0] half;

   assign limit = {1'b0, ratio_code_in};
   assign half = (limit + 4'h1) >> 1;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= mclk_in;
      end
   end

   // Divide by code+1, code zero stops the clock
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count_q <= 4'h0;
         sclk_out <= 1'b0;
         sclk_rise_out <= 1'b0;
         sclk_fall_out <= 1'b0;
      end else begin
         sclk_rise_out <= 1'b0;
         sclk_fall_out <= 1'b0;
         if (ratio_code_in == 3'h0) begin // RL16
            count_q <= 4'h0;
            sclk_out <= 1'b0;
         end else if (mclk_in && !mclk_q) begin // RL16
            if (count_q >= limit) begin
               count_q <= 4'h0;
               sclk_out <= 1'b1;
               sclk_rise_out <= 1'b1;
            end else begin
               count_q <= count_q + 4'h1;
               if (count_q + 4'h1 == half) begin
                  sclk_out <= 1'b0;
                  sclk_fall_out <= 1'b1;
               end
            end
         end
      end
   end
endmodule // crx_clk_div
`default_nettype wire

// file: logic/crx_slot_framing.sv
// Codec receive slot framing configuration with APB registers
// Overview of operation
// RL1 - Both configuration registers act only in mode five.
// RL2 - Sample width code: 8,16,18,20,24,32 bits; two codes reserved.
// RL3 - Sample width does not apply to command address and data slots.
// RL4 - Slot length code: 8,16,18,20,24,32 clocks per slot.
// RL5 - Code 100b means 24, 101b means 32, 110b/111b reserved.
// RL6 - Format register top two bits read zero and ignore writes.
// RL7 - Data delay bit shifts data one serial clock after sync edge.
// RL8 - Tristate bit floats output in invalid slots, else drives zeros.
// RL9 - Clock polarity chooses sync launch edge and input sample edge.
// RL10 - Sync polarity sets frame sync active high or low.
// RL11 - Sync length: whole slot zero or exactly one clock.
// RL12 - Byte order bit reverses bytes of each DMA sample.
// RL13 - Clock direction bit makes serial clock input or output.
// RL14 - Sync direction bit makes frame sync input or output.
// RL15 - Codec supplies clock or sync when set to input; an input sync only feeds frame_start, and the frame counters ignore it.
// RL16 - Serial clock divides master clock output; code zero stops it.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module crx_slot_framing
   import crx_pkg::*;
#(
   parameter int SLOTS = 8
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Codec link
   input wire logic codec_master_clock_out_in,
   input wire logic codec_serial_clock_in,
   output logic codec_serial_clock_out,
   output logic codec_serial_clock_oe_out,
   input wire logic codec_frame_sync_in,
   output logic codec_frame_sync_out,
   output logic codec_frame_sync_oe_out,
   input wire logic codec_serial_data_in,
   output logic codec_serial_data_out,
   output logic codec_serial_data_oe_out,
   // Sample stream
   input wire logic [31:0] tx_sample_in,
   input wire logic [SLOTS-1:0] slot_valid_in,
   output logic [31:0] rx_sample_out,
   output logic [2:0] rx_slot_out,
   output logic rx_valid_out,
   // DMA byte swap path
   input wire logic [31:0] dma_word_in,
   output logic [31:0] dma_word_out
);

   crx_link_type link_q;
   crx_format_type fmt_q;
   logic [2:0] div_q;
   logic [2:0] mode_q;
   logic active;
   logic [17:0] word_addr;
   logic [31:0] rdata;
   logic hit;
   logic [5:0] slot_len;
   logic [5:0] sample_bits;
   logic gen_sclk;
   logic gen_rise;
   logic gen_fall;
   logic ext_q;
   logic ext_prev_q;
   logic sync_in_q;
   logic rise;
   logic fall;
   logic launch;
   logic sample;
   logic [5:0] bit_q;
   logic [2:0] slot_q;
   logic [31:0] shreg_q;
   logic [31:0] rxsh_q;
   logic sync_act;
   logic frame_start;
   logic [5:0] data_bit;
   logic in_sample;
   logic [31:0] swapped;
   logic [5:0] slot_bits_q;

   assign active = (mode_q == CRX_MODE_FIVE); // RL1
   assign word_addr = paddr_in[17:0];

   ////////////////////////////////////////////////////////////////////////
   // APB register file

   always_comb begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      case (word_addr)
         CRX_LINK_CONTROL_ADDR: rdata = {24'h0, link_q};
         CRX_SLOT_FORMAT_ADDR: rdata = {24'h0, 2'b00, fmt_q[5:0]}; // RL6
         CRX_DIVIDER_ADDR: rdata = {29'h0, div_q};
         CRX_MODE_ADDR: rdata = {29'h0, mode_q};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link_q <= CRX_LINK_CONTROL_RST;
         fmt_q <= CRX_SLOT_FORMAT_RST;
         div_q <= CRX_DIVIDER_RST;
         mode_q <= CRX_MODE_RST;
      end else if (psel_in && penable_in && pwrite_in && hit) begin
         case (word_addr)
            CRX_LINK_CONTROL_ADDR: link_q <= pwdata_in[7:0];
            CRX_SLOT_FORMAT_ADDR:
               fmt_q <= pwdata_in[7:0] & CRX_SLOT_FORMAT_MASK; // RL6
            CRX_DIVIDER_ADDR: div_q <= pwdata_in[2:0];
            CRX_MODE_ADDR: mode_q <= pwdata_in[2:0];
            default: fmt_q <= fmt_q;
         endcase
      end
   end

   // Zero wait states: ready in the access cycle
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !hit;
         if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Code decode

   always_comb begin
      case (fmt_q.slot_length_code) // RL4 RL5
         3'h0: slot_len = 6'd8;
         3'h1: slot_len = 6'd16;
         3'h2: slot_len = 6'd18;
         3'h3: slot_len = 6'd20;
         3'h4: slot_len = 6'd24;
         3'h5: slot_len = 6'd32;
         default: slot_len = 6'd32;
      endcase
      case (fmt_q.sample_width_code) // RL2 RL5
         3'h0: sample_bits = 6'd8;
         3'h1: sample_bits = 6'd16;
         3'h2: sample_bits = 6'd18;
         3'h3: sample_bits = 6'd20;
         3'h4: sample_bits = 6'd24;
         3'h5: sample_bits = 6'd32;
         default: sample_bits = 6'd32;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial clock source and edges

   crx_clk_div u_div (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ratio_code_in(div_q),
      .mclk_in(codec_master_clock_out_in),
      .sclk_out(gen_sclk),
      .sclk_rise_out(gen_rise),
      .sclk_fall_out(gen_fall)
   );

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_q <= 1'b0;
         ext_prev_q <= 1'b0;
         sync_in_q <= 1'b0;
      end else begin
         ext_q <= codec_serial_clock_in;
         ext_prev_q <= ext_q;
         sync_in_q <= codec_frame_sync_in;
      end
   end

   assign rise = link_q.clock_direction_bit ? (ext_q && !ext_prev_q) : gen_rise;
   assign fall = link_q.clock_direction_bit ? (!ext_q && ext_prev_q) : gen_fall;
   assign launch = link_q.clock_polarity_bit ? fall : rise; // RL9
   assign sample = link_q.clock_polarity_bit ? rise : fall; // RL9

   ////////////////////////////////////////////////////////////////////////
   // Frame counters

   // External sync start taken at its active level, polarity applied
   assign frame_start = link_q.sync_direction_bit ? // RL14 RL15
      ((sync_in_q == link_q.sync_polarity_bit) && bit_q == 6'd0
       && slot_q == 3'h0) : 1'b0;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_q <= 6'd0;
         slot_q <= 3'h0;
         slot_bits_q <= 6'd8;
      end else if (!active) begin // RL1
         bit_q <= 6'd0;
         slot_q <= 3'h0;
         slot_bits_q <= slot_len;
      end else if (launch) begin
         if (bit_q + 6'd1 >= slot_bits_q) begin
            bit_q <= 6'd0;
            slot_q <= slot_q + 3'h1;
            slot_bits_q <= slot_len;
         end else begin
            bit_q <= bit_q + 6'd1;
         end
      end
   end

   // Active window: one clock or all of slot zero
   assign sync_act = (slot_q == 3'h0) && // RL11
      (link_q.sync_length_bit || bit_q == 6'd0);

   // Data starts one clock late when delay set
   assign data_bit = link_q.data_delay_bit ? bit_q - 6'd1 : bit_q; // RL7
   // Slot zero carries command words at full slot width
   assign in_sample = (slot_q == 3'h0) ? (data_bit < slot_bits_q) // RL3
      : (data_bit < sample_bits); // RL2
   assign swapped = {dma_word_in[7:0], dma_word_in[15:8],
      dma_word_in[23:16], dma_word_in[31:24]};

   ////////////////////////////////////////////////////////////////////////
   // Link outputs

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         codec_serial_clock_out <= 1'b0;
         codec_serial_clock_oe_out <= 1'b0;
         codec_frame_sync_out <= 1'b0;
         codec_frame_sync_oe_out <= 1'b0;
      end else begin
         codec_serial_clock_out <= gen_sclk;
         codec_serial_clock_oe_out <= active && !link_q.clock_direction_bit
            && (div_q != 3'h0); // RL13 RL16
         codec_frame_sync_oe_out <= active && !link_q.sync_direction_bit; // RL14
         if (!active) begin
            codec_frame_sync_out <= !link_q.sync_polarity_bit;
         end else if (launch) begin
            codec_frame_sync_out <= sync_act ~^ link_q.sync_polarity_bit; // RL10
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         codec_serial_data_out <= 1'b0;
         codec_serial_data_oe_out <= 1'b0;
         shreg_q <= 32'h0000_0000;
      end else if (!active) begin
         codec_serial_data_oe_out <= 1'b0;
         codec_serial_data_out <= 1'b0;
      end else if (launch) begin
         if (data_bit == 6'd0) begin
            shreg_q <= tx_sample_in;
         end else begin
            shreg_q <= {shreg_q[30:0], 1'b0};
         end
         if (slot_valid_in[slot_q] && in_sample) begin
            codec_serial_data_out <= (data_bit == 6'd0) ? tx_sample_in[31]
               : shreg_q[30];
            codec_serial_data_oe_out <= 1'b1;
         end else begin
            codec_serial_data_out <= 1'b0; // RL8
            codec_serial_data_oe_out <= !link_q.tristate_enable_bit; // RL8
         end
      end
   end

   // Receive shift, MSB first, sampled on the opposite edge
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rxsh_q <= 32'h0000_0000;
         rx_sample_out <= 32'h0000_0000;
         rx_slot_out <= 3'h0;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= 1'b0;
         if (active && sample && in_sample) begin
            rxsh_q <= {rxsh_q[30:0], codec_serial_data_in};
            if (data_bit + 6'd1 == ((slot_q == 3'h0) ? slot_bits_q
                  : sample_bits)) begin
               rx_sample_out <= {rxsh_q[30:0], codec_serial_data_in};
               rx_slot_out <= slot_q;
               rx_valid_out <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dma_word_out <= 32'h0000_0000;
      end else begin
         dma_word_out <= (active && link_q.byte_order_bit) ? swapped
            : dma_word_in; // RL1 RL12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   fmt_top_zero_a: assert property (@(posedge clk_in) // RL6
      disable iff (!rst_b_in) fmt_q[7:6] == 2'b00)
      else $error("format top bits set");
   oe_off_idle_a: assert property (@(posedge clk_in) // RL1
      disable iff (!rst_b_in) !active |=> !codec_frame_sync_oe_out)
      else $error("sync driven");
   clk_in_dir_a: assert property (@(posedge clk_in) // RL13
      disable iff (!rst_b_in)
      link_q.clock_direction_bit |=> !codec_serial_clock_oe_out)
      else $error("clock driven while input");
   sync_in_dir_a: assert property (@(posedge clk_in) // RL14
      disable iff (!rst_b_in)
      link_q.sync_direction_bit |=> !codec_frame_sync_oe_out)
      else $error("sync driven while input");
   div_off_a: assert property (@(posedge clk_in) // RL16
      disable iff (!rst_b_in) div_q == 3'h0 |=> !codec_serial_clock_oe_out)
      else $error("clock on while divider off");
   swap_path_a: assert property (@(posedge clk_in) // RL12
      disable iff (!rst_b_in)
      active && link_q.byte_order_bit && $stable(link_q) |=>
      dma_word_out == {$past(dma_word_in[7:0]), $past(dma_word_in[15:8]),
      $past(dma_word_in[23:16]), $past(dma_word_in[31:24])})
      else $error("byte swap wrong");
   zero_pad_a: assert property (@(posedge clk_in) // RL8
      disable iff (!rst_b_in)
      active && launch && !slot_valid_in[slot_q] && !link_q.tristate_enable_bit
      |=> codec_serial_data_oe_out && !codec_serial_data_out)
      else $error("no zero pad");
   sync_level_a: assert property (@(posedge clk_in) // RL10 RL11
      disable iff (!rst_b_in) active && launch && slot_q != 3'h0 |=>
      codec_frame_sync_out == !$past(link_q.sync_polarity_bit))
      else $error("sync active outside slot zero");
   slot_len_a: assert property (@(posedge clk_in) // RL4
      disable iff (!rst_b_in) active |-> bit_q < slot_bits_q)
      else $error("slot count overrun");
   ext_sync_a: assert property (@(posedge clk_in) // RL14
      disable iff (!rst_b_in) frame_start |=> !codec_frame_sync_oe_out)
      else $error("sync driven against codec");
   rx_gated_a: assert property (@(posedge clk_in) // RL1
      disable iff (!rst_b_in) !active |=> !rx_valid_out)
      else $error("receive while idle");

endmodule // crx_slot_framing
`default_nettype wire

// file: test/crx_codec_model.sv
// Behavioural codec supplying serial clock, frame sync and data
`timescale 1ns/1ps
`default_nettype none
module crx_codec_model #(
   parameter int HALF = 4,
   parameter int FRAME = 128
)(
   // Clock
   input wire logic clk_in,
   // Bench control
   input wire logic run_in,
   // Link pins
   output logic sclk_out,
   output logic sync_out,
   output logic data_out
);
   int div_q = 0;
   int bit_q = 0;
   logic [15:0] lfsr_q = 16'hACE1;
   initial sclk_out = 1'b0;
   initial sync_out = 1'b0;
   initial data_out = 1'b0;
   // Clock stands still unless the codec is told to run
   always @(posedge clk_in) begin
      if (run_in) begin
         div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
         if (div_q == HALF - 1) begin
            sclk_out <= ~sclk_out;
            if (sclk_out) begin
               bit_q <= (bit_q == FRAME - 1) ? 0 : bit_q + 1;
               sync_out <= (bit_q == FRAME - 1);
               lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]};
               data_out <= lfsr_q[0];
            end
         end
      end
   end
endmodule // crx_codec_model
`default_nettype wire

// file: test/crx_slot_framing_tb_top.sv
// Self-checking bench for the codec receive slot framing block
`timescale 1ns/1ps
`default_nettype none
module crx_slot_framing_tb_top;
   import crx_pkg::*;
   localparam logic [31:0] A_CTL = {14'h0, CRX_LINK_CONTROL_ADDR};
   localparam logic [31:0] A_FMT = {14'h0, CRX_SLOT_FORMAT_ADDR};
   localparam logic [31:0] A_DIV = {14'h0, CRX_DIVIDER_ADDR};
   localparam logic [31:0] A_MODE = {14'h0, CRX_MODE_ADDR};
   localparam logic [31:0] A_BAD = 32'h0000_0040;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mclk = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rx_sample, dma_out;
   logic [31:0] tx_sample = 32'h0, dma_in = 32'h0, seed_q = 32'h0FE0;
   logic [7:0] slot_valid = 8'h00;
   logic [2:0] rx_slot;
   logic pready, pslverr, rx_valid, sclk_o, sclk_oe, sync_o, sync_oe;
   logic sd_o, sd_oe, m_sclk, m_sync, m_data, sclk_pin, sync_pin;
   logic run_model = 1'b0;
   logic [31:0] rx_ref = 32'h0;
   logic sclk_prev = 1'b0;
   int fail_count = 0, total_checks = 0, cycles = 0;

   always #10 clk_in = ~clk_in;
   assign sclk_pin = sclk_oe ? sclk_o : m_sclk;
   assign sync_pin = sync_oe ? sync_o : m_sync;

   crx_slot_framing u_crx_slot_framing (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .codec_master_clock_out_in(mclk), .codec_serial_clock_in(sclk_pin),
      .codec_serial_clock_out(sclk_o), .codec_serial_clock_oe_out(sclk_oe),
      .codec_frame_sync_in(sync_pin), .codec_frame_sync_out(sync_o),
      .codec_frame_sync_oe_out(sync_oe), .codec_serial_data_in(m_data),
      .codec_serial_data_out(sd_o), .codec_serial_data_oe_out(sd_oe),
      .tx_sample_in(tx_sample), .slot_valid_in(slot_valid),
      .rx_sample_out(rx_sample), .rx_slot_out(rx_slot),
      .rx_valid_out(rx_valid), .dma_word_in(dma_in), .dma_word_out(dma_out));

   crx_codec_model u_crx_codec_model (.clk_in(clk_in), .run_in(run_model),
      .sclk_out(m_sclk), .sync_out(m_sync), .data_out(m_data));

   // Reference of bits on the data input, taken at each rising pin edge
   always @(posedge clk_in) begin
      sclk_prev <= sclk_pin;
      if (sclk_pin && !sclk_prev) begin
         rx_ref <= {rx_ref[30:0], m_data};
      end
   end

   function automatic logic [31:0] rnd();
      seed_q = seed_q ^ (seed_q << 13);
      seed_q = seed_q ^ (seed_q >> 17);
      seed_q = seed_q ^ (seed_q << 5);
      return seed_q;
   endfunction

   function automatic int slot_len(input logic [2:0] c);
      case (c)
         3'h0: return 8;
         3'h1: return 16;
         3'h2: return 18;
         3'h3: return 20;
         3'h4: return 24;
         default: return 32;
      endcase
   endfunction

   function automatic logic [31:0] swap(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   always @(posedge clk_in) begin
      mclk <= ~mclk;
      tx_sample <= rnd();
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [7:0] x,
         input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, {24'h0, x});
      check({31'h0, e}, {31'h0, xe});
   endtask

   // Sample edges seen while frame sync is active in one pulse
   task automatic pulse_len(input logic act, input logic rise, output int n);
      logic p;
      n = 0;
      while (sync_pin !== ~act) @(posedge clk_in);
      while (sync_pin !== act) @(posedge clk_in);
      p = sclk_pin;
      while (sync_pin === act) begin
         @(posedge clk_in);
         if (sclk_pin !== p && sclk_pin === rise && sync_pin === act) n++;
         p = sclk_pin;
      end
   endtask

   task automatic watch(input int cyc, output int ns, output int nc,
         output int noe, output int n1, output int nv);
      logic ps, pc;
      logic [2:0] ls;
      ns = 0;
      nc = 0;
      noe = 0;
      n1 = 0;
      nv = 0;
      ls = 3'h0;
      // Let pending launches apply the new settings first
      repeat (16) @(posedge clk_in);
      ps = sync_pin;
      pc = sclk_pin;
      repeat (cyc) begin
         @(posedge clk_in);
         if (sync_pin !== ps) ns++;
         if (sclk_pin !== pc) nc++;
         if (sd_oe === 1'b1) noe++;
         if (sd_oe === 1'b1 && sd_o !== 1'b0) n1++;
         if (rx_valid === 1'b1) begin
            check({16'h0, rx_sample[15:0]}, {16'h0, rx_ref[15:0]});
            if (nv > 0) check({29'h0, rx_slot}, {29'h0, ls + 3'h1});
            ls = rx_slot;
            nv++;
         end
         ps = sync_pin;
         pc = sclk_pin;
      end
   endtask

   initial begin
      int n, ns, nc, noe, n1, nv;
      logic [31:0] w;
      logic [7:0] v;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd_chk(A_CTL, 8'h30, 1'b0);
      rd_chk(A_FMT, 8'h00, 1'b0);
      rd_chk(A_DIV, 8'h00, 1'b0);
      for (int i = 0; i < 6; i++) begin
         v = 8'(rnd());
         wr(A_FMT, v);
         rd_chk(A_FMT, v & 8'h3F, 1'b0);
         v = 8'(rnd());
         wr(A_CTL, v);
         rd_chk(A_CTL, v, 1'b0);
      end
      wr(A_CTL, 8'h30);
      wr(A_BAD, 8'hFF);
      rd_chk(A_BAD, 8'h00, 1'b1);
      rd_chk(A_CTL, 8'h30, 1'b0);
      // Byte order only in mode five
      for (int m = 0; m < 2; m++) begin
         wr(A_MODE, m ? 8'h05 : 8'h00);
         for (int b = 0; b < 2; b++) begin
            wr(A_CTL, b ? 8'h34 : 8'h30);
            repeat (6) begin
               w = rnd();
               @(posedge clk_in);
               dma_in <= w;
               @(posedge clk_in);
               @(posedge clk_in);
               check(dma_out, (b && m) ? swap(w) : w);
            end
         end
      end
      slot_valid <= 8'hFF;
      wr(A_DIV, 8'h03);
      wr(A_CTL, 8'h30);
      repeat (4) @(posedge clk_in);
      check({30'h0, sclk_oe, sync_oe}, 32'h3);
      // Sync length, polarity and edge over slot length codes 0 to 5
      for (int i = 0; i < 8; i++) begin
         wr(A_FMT, {2'b00, 3'(i % 6), 3'(i % 6)});
         wr(A_CTL, {2'b00, 1'(i), 1'(i >> 1), 1'(i < 6), 3'b000});
         pulse_len(1'(i >> 1), 1'(i), n);
         pulse_len(1'(i >> 1), 1'(i), n);
         check(n, (i < 6) ? slot_len(3'(i % 6)) : 1);
      end
      // Invalid slots floated, then zero padded
      slot_valid <= 8'h00;
      wr(A_FMT, 8'h09);
      wr(A_CTL, 8'h70);
      watch(2500, ns, nc, noe, n1, nv);
      check(noe, 0);
      wr(A_CTL, 8'h30);
      watch(2500, ns, nc, noe, n1, nv);
      check(n1, 0);
      check(noe > 0, 1);
      wr(A_DIV, 8'h00);
      watch(300, ns, nc, noe, n1, nv);
      check(nc, 0);
      wr(A_DIV, 8'h03);
      wr(A_MODE, 8'h00);
      watch(2500, ns, nc, noe, n1, nv);
      check(ns, 0);
      // Codec supplies clock and sync
      slot_valid <= 8'hFF;
      wr(A_MODE, 8'h05);
      wr(A_DIV, 8'h00);
      wr(A_CTL, 8'h33);
      run_model <= 1'b1;
      watch(3000, ns, nc, noe, n1, nv);
      check({30'h0, sclk_oe, sync_oe}, 32'h0);
      check(nv > 0, 1);
      end_of_test();
   end
endmodule // crx_slot_framing_tb_top
`default_nettype wire
